// *** hdl/itrc_pkg.sv ***
// constants, register map and types of the input terminal run control block
package itrc_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_FILTER    = 8'h00;
  localparam logic [7:0] ADDR_QUALIFY   = 8'h04;
  localparam logic [7:0] ADDR_POLARITY  = 8'h08;
  localparam logic [7:0] ADDR_RUNMODE   = 8'h0C;
  localparam logic [7:0] ADDR_CONFIG    = 8'h10;
  localparam logic [7:0] ADDR_FUNC_BASE = 8'h20;
  localparam logic [7:0] ADDR_LEVELS    = 8'h40;
  localparam logic [7:0] ADDR_COUNT     = 8'h44;
  localparam logic [7:0] ADDR_TIMER     = 8'h48;
  localparam logic [7:0] ADDR_STATUS    = 8'h4C;

  // reset values
  localparam logic [3:0] RST_FILTER   = 4'h5;
  localparam logic       RST_QUALIFY  = 1'b0;
  localparam logic [6:0] RST_POLARITY = 7'h00;
  localparam logic [4:0] RST_CONFIG   = 5'h00;
  localparam logic [6:0] RST_FUNC     = 7'h00;

  // filter count limits
  localparam logic [3:0] FILTER_MIN = 4'h1;
  localparam logic [3:0] FILTER_MAX = 4'hA;

  // config register bit positions
  localparam int CFG_SRC_LOOP    = 0;
  localparam int CFG_LOOP_MANUAL = 1;
  localparam int CFG_OSC_MANUAL  = 2;
  localparam int CFG_SEQ_MANUAL  = 3;
  localparam int CFG_CTRL_TERM   = 4;
  localparam int CFG_COUNT_DOWN  = 5;

  // terminal function codes
  localparam logic [6:0] FN_FWD       = 7'h01;
  localparam logic [6:0] FN_REV       = 7'h02;
  localparam logic [6:0] FN_STOP_EN   = 7'h03;
  localparam logic [6:0] FN_LOOP_RUN  = 7'h21;
  localparam logic [6:0] FN_LOOP_HOLD = 7'h22;
  localparam logic [6:0] FN_OSC_CTRL  = 7'h23;
  localparam logic [6:0] FN_OSC_HOLD  = 7'h24;
  localparam logic [6:0] FN_OSC_RST   = 7'h25;
  localparam logic [6:0] FN_SEQ_EN    = 7'h26;
  localparam logic [6:0] FN_SEQ_HOLD  = 7'h27;
  localparam logic [6:0] FN_SEQ_RST   = 7'h28;
  localparam logic [6:0] FN_CNT_CLR   = 7'h29;
  localparam logic [6:0] FN_CNT_TRIG  = 7'h2A;
  localparam logic [6:0] FN_TMR_TRIG  = 7'h2B;
  localparam logic [6:0] FN_TMR_CLR   = 7'h2C;
  localparam logic [6:0] FN_PULSE_REF = 7'h2D;
  localparam logic [6:0] FN_LEN_PULSE = 7'h2F;
  localparam logic [6:0] FN_TORQUE    = 7'h30;
  localparam logic [6:0] FN_TRQ_BLOCK = 7'h31;
  localparam logic [6:0] FN_LOCK_ONE  = 7'h3C;
  localparam logic [6:0] FN_LOCK_TWO  = 7'h3D;
  localparam logic [6:0] FN_LOCK_THR  = 7'h3E;
  localparam logic [6:0] FN_SRC_B     = 7'h40;

  // only the sixth terminal takes the fast pulse functions
  localparam int FAST_TERM = 5;

  // timing
  localparam longint CLK_HZ      = 40000000;
  localparam longint SAMPLE_US   = 200;
  localparam int     SAMPLE_CYC  = int'((CLK_HZ * SAMPLE_US) / 1000000);
  localparam logic [3:0] SETTLE_TICKS = 4'hB;
  localparam logic [15:0] COUNT_INIT  = 16'h0000;

  typedef enum logic [1:0] {
    MODE_2W_IND  = 2'b00,
    MODE_2W_DIR  = 2'b01,
    MODE_3W_TRIG = 2'b10,
    MODE_3W_DIR  = 2'b11
  } itrc_run_mode_t;
endpackage

// *** hdl/itrc_input_terminal_run_control.sv ***
// input terminal conditioning, function decoding and run control with apb registers
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/10ps
//
// Overview of operation
// - loop-control input, loop frequency source and manual loop mode enter loop running.
// - loop-pause input freezes loop adjustment and holds frequency; release resumes.
// - manual oscillation mode oscillates only while its input is active.
// - oscillation-pause input holds the present frequency until release.
// - oscillation-reset clears oscillation state; release restarts with preset first.
// - manual sequencer mode runs sequencer only with enable input, else zero frequency.
// - sequencer pause gives zero frequency, stops step timing, release speed-tracks.
// - sequencer reset while stopped clears step, time and frequency; restart after release.
// - count-clear input resets the event counter to its initial value.
// - each count-trigger pulse counts up or down; source stays below 200 Hz.
// - timer runs from its trigger input and is reset by timer-clear.
// - pulse reference and length pulse act only on the sixth terminal.
// - with terminal switching, switch input selects torque; prohibit input disables torque.
// - interlocks one, two, three drive collector out one, two and relay one.
// - source switch moves reference to B when running, selects B and starts when stopped.
// - input filter count one to ten, default five.
// - qualify zero blocks a run terminal closed at power-up until reopened.
// - seven polarity bits invert the active level of each terminal.
// - two-wire mode zero: forward and reverse each run their own direction.
// - two-wire mode one: forward is run/stop, reverse selects direction.
// - three-wire mode two: triggers need stop-enable; opening it stops.
// - three-wire mode three: run trigger starts forward, direction trigger then reverses.
module itrc_input_terminal_run_control
  import itrc_pkg::*;
#(
  parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYC,
  parameter int unsigned NUM_TERMS     = 7
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // terminals, high while closed to common_return
  input  wire logic [NUM_TERMS-1:0] term_in,
  // run command
  output logic                      run_cmd,
  output logic                      run_reverse,
  output logic                      src_b_select,
  // process loop and oscillation
  output logic                      loop_run,
  output logic                      loop_hold,
  output logic                      osc_enable,
  output logic                      osc_hold,
  output logic                      osc_reset,
  output logic                      osc_restart,
  // step sequencer
  output logic                      seq_enable,
  output logic                      seq_zero_freq,
  output logic                      seq_timing_hold,
  output logic                      seq_speed_track,
  output logic                      seq_reset,
  output logic                      seq_restart,
  // fast pulse, control mode and interlocks
  output logic                      pulse_ref_level,
  output logic                      length_pulse,
  output logic                      torque_mode,
  output logic                      open_collector_out_one,
  output logic                      open_collector_out_two,
  output logic                      relay_out_one
);

  localparam int DIV_W = $clog2(SAMPLE_CYCLES + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SAMPLE_CYCLES - 1);

  // registers
  logic [3:0]     filter_reg;
  logic           qualify_reg;
  logic [6:0]     polarity_reg;
  itrc_run_mode_t mode_reg;
  logic [5:0]     config_reg;
  logic [6:0]     func_reg [NUM_TERMS];
  logic [15:0]    count_reg;
  logic [15:0]    timer_reg;

  // apb decode
  wire       wr_en    = psel & penable & pwrite;
  wire       setup    = psel & ~penable;
  wire [7:0] func_off = paddr - ADDR_FUNC_BASE;
  wire       func_hit = (paddr >= ADDR_FUNC_BASE) && (func_off[7:2] < 6'(NUM_TERMS)) && (paddr[1:0] == 2'b00);
  wire [2:0] func_idx = func_off[4:2];
  wire       hit      = func_hit || (paddr inside {ADDR_FILTER, ADDR_QUALIFY, ADDR_POLARITY, ADDR_RUNMODE,
                                     ADDR_CONFIG, ADDR_LEVELS, ADDR_COUNT, ADDR_TIMER, ADDR_STATUS});
  wire [3:0] wr_filter = (pwdata[3:0] < FILTER_MIN) ? FILTER_MIN :
                         (pwdata[3:0] > FILTER_MAX || pwdata[7:4] != 4'h0) ? FILTER_MAX : pwdata[3:0];

  // sample divider and synchroniser
  logic [DIV_W-1:0]     div_reg;
  logic [NUM_TERMS-1:0] sync1_reg;
  logic [NUM_TERMS-1:0] sync2_reg;
  logic [NUM_TERMS-1:0] filt_level;
  logic [NUM_TERMS-1:0] filt_d_reg;
  logic [3:0]           settle_reg;
  wire                  tick = (div_reg == DIV_LAST);
  wire [NUM_TERMS-1:0]  cond = sync2_reg ^ polarity_reg[NUM_TERMS-1:0];
  wire [NUM_TERMS-1:0]  rise = filt_level & ~filt_d_reg;
  wire [NUM_TERMS-1:0]  fall = ~filt_level & filt_d_reg;
  wire                  settled = (settle_reg == SETTLE_TICKS);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg    <= '0;
      sync1_reg  <= '0;
      sync2_reg  <= '0;
      filt_d_reg <= '0;
      settle_reg <= 4'h0;
    end else begin
      div_reg    <= tick ? '0 : div_reg + DIV_W'(1);
      sync1_reg  <= term_in;
      sync2_reg  <= sync1_reg;
      filt_d_reg <= filt_level;
      if (tick && !settled) begin
        settle_reg <= settle_reg + 4'h1;
      end
    end
  end

  // a level must hold for filter_reg samples before it is taken
  for (genvar i = 0; i < NUM_TERMS; i++) begin : g_filt
    logic [3:0] cnt_reg;
    logic       lvl_reg;
    assign filt_level[i] = lvl_reg;
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        cnt_reg <= 4'h0;
        lvl_reg <= 1'b0;
      end else if (tick) begin
        if (cond[i] == lvl_reg) begin
          cnt_reg <= 4'h0;
        end else if (cnt_reg + 4'h1 >= filter_reg) begin
          lvl_reg <= cond[i];
          cnt_reg <= 4'h0;
        end else begin
          cnt_reg <= cnt_reg + 4'h1;
        end
      end
    end
  end

  // any terminal assigned to a function may drive it
  function automatic logic fn_hit(input logic [6:0] code, input logic [NUM_TERMS-1:0] vec);
    logic hit_v;
    hit_v = 1'b0;
    for (int k = 0; k < NUM_TERMS; k++) begin
      hit_v = hit_v | ((func_reg[k] == code) & vec[k]);
    end
    return hit_v;
  endfunction

  wire f_fwd     = fn_hit(FN_FWD, filt_level);
  wire f_rev     = fn_hit(FN_REV, filt_level);
  wire f_stop    = fn_hit(FN_STOP_EN, filt_level);
  wire r_fwd     = fn_hit(FN_FWD, rise);
  wire r_rev     = fn_hit(FN_REV, rise);
  wire f_srcb    = fn_hit(FN_SRC_B, filt_level);
  wire r_srcb    = fn_hit(FN_SRC_B, rise);
  wire f_cnt_clr = fn_hit(FN_CNT_CLR, filt_level);
  wire r_cnt     = fn_hit(FN_CNT_TRIG, rise);
  wire f_lock1   = fn_hit(FN_LOCK_ONE, filt_level);
  wire f_seq_en  = fn_hit(FN_SEQ_EN, filt_level);
  wire f_seq_hld = fn_hit(FN_SEQ_HOLD, filt_level);
  wire count_dn  = config_reg[CFG_COUNT_DOWN];

  // run control
  logic run_reg;
  logic rev_reg;
  logic block_reg;
  logic src_run_reg;
  logic run_next;
  logic rev_next;

  always_comb begin
    run_next = run_reg;
    rev_next = rev_reg;
    unique case (mode_reg)
      MODE_2W_IND: begin
        run_next = f_fwd ^ f_rev;
        rev_next = f_rev & ~f_fwd;
      end
      MODE_2W_DIR: begin
        run_next = f_fwd;
        rev_next = f_rev;
      end
      MODE_3W_TRIG: begin
        if (!f_stop) begin
          run_next = 1'b0;
        end else if (r_fwd) begin
          run_next = 1'b1;
          rev_next = 1'b0;
        end else if (r_rev) begin
          run_next = 1'b1;
          rev_next = 1'b1;
        end
      end
      MODE_3W_DIR: begin
        if (!f_stop) begin
          run_next = 1'b0;
        end else if (!run_reg && r_fwd) begin
          run_next = 1'b1;
          rev_next = 1'b0;
        end else if (run_reg && r_rev) begin
          rev_next = ~rev_reg;
        end
      end
    endcase
    if (block_reg) begin
      run_next = 1'b0;
    end
  end

  // with qualify zero the block lifts only after the filters have settled, so a closed terminal is seen as closed
  wire block_next = block_reg & ~(qualify_reg | (settled & ~f_fwd & ~f_rev));
  wire running    = run_reg | src_run_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_reg     <= 1'b0;
      rev_reg     <= 1'b0;
      block_reg   <= 1'b1;
      src_run_reg <= 1'b0;
    end else begin
      run_reg     <= run_next;
      rev_reg     <= rev_next;
      block_reg   <= block_next;
      src_run_reg <= f_srcb & (src_run_reg | (r_srcb & ~running));
    end
  end

  // registered function outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {run_cmd, run_reverse, src_b_select, loop_run, loop_hold, osc_enable, osc_hold} <= '0;
      {osc_reset, osc_restart, seq_enable, seq_zero_freq, seq_timing_hold} <= '0;
      {seq_speed_track, seq_reset, seq_restart, pulse_ref_level, length_pulse, torque_mode} <= '0;
      {open_collector_out_one, open_collector_out_two, relay_out_one} <= '0;
    end else begin
      run_cmd         <= running;
      run_reverse     <= rev_reg & run_reg;
      src_b_select    <= f_srcb;
      loop_run        <= fn_hit(FN_LOOP_RUN, filt_level) & config_reg[CFG_SRC_LOOP]
                         & config_reg[CFG_LOOP_MANUAL];
      loop_hold       <= fn_hit(FN_LOOP_HOLD, filt_level);
      osc_enable      <= ~config_reg[CFG_OSC_MANUAL] | fn_hit(FN_OSC_CTRL, filt_level);
      osc_hold        <= fn_hit(FN_OSC_HOLD, filt_level);
      osc_reset       <= fn_hit(FN_OSC_RST, filt_level);
      osc_restart     <= fn_hit(FN_OSC_RST, fall);
      seq_enable      <= running & (~config_reg[CFG_SEQ_MANUAL] | f_seq_en) & ~f_seq_hld;
      seq_zero_freq   <= running & ((config_reg[CFG_SEQ_MANUAL] & ~f_seq_en) | f_seq_hld);
      seq_timing_hold <= f_seq_hld;
      seq_speed_track <= fn_hit(FN_SEQ_HOLD, fall) & running;
      seq_reset       <= fn_hit(FN_SEQ_RST, filt_level) & ~running;
      seq_restart     <= fn_hit(FN_SEQ_RST, fall) & ~running;
      pulse_ref_level <= (func_reg[FAST_TERM] == FN_PULSE_REF) & filt_level[FAST_TERM];
      length_pulse    <= (func_reg[FAST_TERM] == FN_LEN_PULSE) & rise[FAST_TERM];
      torque_mode     <= config_reg[CFG_CTRL_TERM] & fn_hit(FN_TORQUE, filt_level)
                         & ~fn_hit(FN_TRQ_BLOCK, filt_level);
      open_collector_out_one <= f_lock1;
      open_collector_out_two <= fn_hit(FN_LOCK_TWO, filt_level);
      relay_out_one          <= fn_hit(FN_LOCK_THR, filt_level);
    end
  end

  // counter and timer; clear wins over a step in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= COUNT_INIT;
      timer_reg <= 16'h0000;
    end else begin
      if (f_cnt_clr) begin
        count_reg <= COUNT_INIT;
      end else if (r_cnt) begin
        count_reg <= count_dn ? count_reg - 16'h0001 : count_reg + 16'h0001;
      end
      if (fn_hit(FN_TMR_CLR, filt_level)) begin
        timer_reg <= 16'h0000;
      end else if (tick && fn_hit(FN_TMR_TRIG, filt_level)) begin
        timer_reg <= timer_reg + 16'h0001;
      end
    end
  end

  // register writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      filter_reg   <= RST_FILTER;
      qualify_reg  <= RST_QUALIFY;
      polarity_reg <= RST_POLARITY;
      mode_reg     <= MODE_2W_IND;
      config_reg   <= {1'b0, RST_CONFIG};
      for (int k = 0; k < NUM_TERMS; k++) begin
        func_reg[k] <= RST_FUNC;
      end
    end else if (wr_en) begin
      if (paddr == ADDR_FILTER) filter_reg <= wr_filter;
      if (paddr == ADDR_QUALIFY) qualify_reg <= pwdata[0];
      if (paddr == ADDR_POLARITY) polarity_reg <= pwdata[6:0];
      if (paddr == ADDR_RUNMODE) mode_reg <= itrc_run_mode_t'(pwdata[1:0]);
      if (paddr == ADDR_CONFIG) config_reg <= pwdata[5:0];
      if (func_hit) func_reg[func_idx] <= pwdata[6:0];
    end
  end

  // read data is caught in the setup cycle so the access phase needs no wait state
  wire [31:0] status_word = {24'h0, torque_mode, src_b_select, block_reg, src_run_reg,
                             rev_reg, run_reg, run_reverse, run_cmd};
  wire [31:0] rd_mux =
      func_hit                  ? {25'h0, func_reg[func_idx]} :
      (paddr == ADDR_FILTER)    ? {28'h0, filter_reg} :
      (paddr == ADDR_QUALIFY)   ? {31'h0, qualify_reg} :
      (paddr == ADDR_POLARITY)  ? {25'h0, polarity_reg} :
      (paddr == ADDR_RUNMODE)   ? {30'h0, mode_reg} :
      (paddr == ADDR_CONFIG)    ? {26'h0, config_reg} :
      (paddr == ADDR_LEVELS)    ? {{(32 - NUM_TERMS){1'b0}}, filt_level} :
      (paddr == ADDR_COUNT)     ? {16'h0, count_reg} :
      (paddr == ADDR_TIMER)     ? {16'h0, timer_reg} :
      (paddr == ADDR_STATUS)    ? status_word : 32'h0000_0000;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_filter_range: assert property (filter_reg >= FILTER_MIN && filter_reg <= FILTER_MAX)
    else $error("filter count out of range");
  a_block_no_run: assert property (block_reg |-> !run_reg)
    else $error("run while power-up block active");
  a_two_wire_dir: assert property ((mode_reg == MODE_2W_DIR && !block_reg) |=> run_reg == $past(f_fwd))
    else $error("two-wire run does not follow forward input");
  a_two_wire_ind: assert property ((mode_reg == MODE_2W_IND && !block_reg && f_fwd && f_rev) |=> !run_reg)
    else $error("both inputs active must stop");
  a_stop_enable: assert property ((mode_reg inside {MODE_3W_TRIG, MODE_3W_DIR}) && !f_stop |=> !run_reg)
    else $error("open stop-enable did not stop");
  a_dir_alone: assert property ((mode_reg == MODE_3W_DIR && !run_reg && r_rev && !r_fwd) |=> !run_reg)
    else $error("direction trigger alone started drive");
  a_count_clear: assert property (f_cnt_clr |=> count_reg == COUNT_INIT)
    else $error("counter not cleared");
  a_count_step: assert property ((!f_cnt_clr && r_cnt && !count_dn) |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("counter did not step up");
  a_interlock_out: assert property (f_lock1 |-> ##1 open_collector_out_one)
    else $error("interlock one not on collector out one");
  a_fast_only: assert property ((func_reg[FAST_TERM] != FN_LEN_PULSE) |=> !length_pulse)
    else $error("length pulse from wrong terminal");

endmodule

// *** sim/itrc_switch_model.sv ***
// contact switches that close the input terminals against common_return
`timescale 1ns/10ps
module itrc_switch_model #(
  parameter int unsigned MIN_HOLD = 8
) (
  // clock
  input  wire logic       clk,
  // wanted contact states, 1 = closed
  input  wire logic [6:0] closed_req,
  // terminal pins
  output logic      [6:0] term_in
);
  int unsigned held = MIN_HOLD;

  initial term_in = 7'h00;

  // a contact only moves after its level has stood MIN_HOLD cycles,
  // so count pulses never outrun the terminal filter
  always @(posedge clk) begin
    if (closed_req != term_in && held >= MIN_HOLD) begin
      term_in <= closed_req;
      held    <= 0;
    end else begin
      held <= held + 1;
    end
  end
endmodule

// *** sim/tb_top.sv ***
// self-checking bench for the input terminal run control block
`timescale 1ns/10ps
module tb_top;
  import itrc_pkg::*;

  typedef struct packed {
    logic [6:0]  fn;
    logic [5:0]  cfg;
    logic [11:0] exp;
  } itrc_row_t;

  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [6:0]  sw, term_in;
  logic        run_cmd, run_reverse, src_b_select, loop_run, loop_hold, osc_enable;
  logic        osc_hold, osc_reset, seq_timing_hold, pulse_ref_level, torque_mode;
  logic        open_collector_out_one, open_collector_out_two, relay_out_one;
  logic        seq_enable, seq_zero_freq, seq_reset, length_pulse;
  int          n_len = 0;
  int          n_errors = 0;
  int          cmp_count = 0;

  wire [11:0] lv = {loop_run, loop_hold, osc_enable, osc_hold, osc_reset, seq_timing_hold,
                    pulse_ref_level, torque_mode, open_collector_out_one,
                    open_collector_out_two, relay_out_one, src_b_select};

  // all rows close terminal one; outputs as packed in lv
  itrc_row_t rows [14] = '{
    '{FN_LOOP_RUN, 6'h03, 12'hA00},
    '{FN_LOOP_RUN, 6'h01, 12'h200},
    '{FN_LOOP_HOLD, 6'h00, 12'h600},
    '{FN_OSC_CTRL, 6'h04, 12'h200},
    '{FN_OSC_HOLD, 6'h04, 12'h100},
    '{FN_OSC_RST, 6'h00, 12'h280},
    '{FN_SEQ_HOLD, 6'h00, 12'h240},
    '{FN_PULSE_REF, 6'h00, 12'h200},
    '{FN_TORQUE, 6'h10, 12'h210},
    '{FN_TORQUE, 6'h00, 12'h200},
    '{FN_LOCK_ONE, 6'h00, 12'h208},
    '{FN_LOCK_TWO, 6'h00, 12'h204},
    '{FN_LOCK_THR, 6'h00, 12'h202},
    '{FN_SRC_B, 6'h00, 12'h201}};

  // short sample period keeps filter and settle times small
  itrc_input_terminal_run_control #(.SAMPLE_CYCLES(4)) itrc_input_terminal_run_control_inst (
    .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .term_in, .run_cmd, .run_reverse, .src_b_select, .loop_run, .loop_hold, .osc_enable,
    .osc_hold, .osc_reset, .osc_restart(), .seq_enable, .seq_zero_freq, .seq_timing_hold,
    .seq_speed_track(), .seq_reset, .seq_restart(), .pulse_ref_level, .length_pulse,
    .torque_mode, .open_collector_out_one, .open_collector_out_two, .relay_out_one);

  itrc_switch_model #(.MIN_HOLD(8)) itrc_switch_model_inst (.clk, .closed_req(sw), .term_in);

  // length pulses last one cycle, so they are counted rather than sampled
  always @(posedge clk) begin
    if (length_pulse === 1'b1) n_len <= n_len + 1;
  end

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask

  // long enough for switch hold, sync, one filter tick and output register
  task automatic settle();
    repeat (28) @(posedge clk);
  endtask

  task automatic chkrun(input string nm, input logic [1:0] e);
    chk(nm, 32'(e), 32'({run_cmd, run_reverse}));
  endtask

  task automatic pulse(input int b);
    sw[b] <= 1'b1;
    settle();
    sw[b] <= 1'b0;
    settle();
  endtask

  // checks the run state while the terminal is still closed
  task automatic trig(input int b, input string nm, input logic [1:0] e);
    sw[b] <= 1'b1;
    settle();
    chkrun(nm, e);
    sw[b] <= 1'b0;
    settle();
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("Error watchdog expected finish seen timeout");
    give_verdict();
  end

  initial begin
    {rst_n, psel, penable, pwrite} = 4'h0;
    paddr  = 8'h00;
    pwdata = 32'h0;
    sw     = 7'h01;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    // forward assigned while its terminal is already closed
    wr(ADDR_FUNC_BASE, 32'(FN_FWD));
    rchk("filter", ADDR_FILTER, 32'h5);
    rchk("qualify", ADDR_QUALIFY, 32'h0);
    rchk("polarity", ADDR_POLARITY, 32'h0);
    rchk("runmode", ADDR_RUNMODE, 32'h0);
    rchk("unmapped", 8'hFC, 32'h0);
    chk("slverr", 32'h1, 32'(err));
    wr(ADDR_FILTER, 32'hB);
    rchk("clamp_hi", ADDR_FILTER, 32'hA);
    wr(ADDR_FILTER, 32'h0);
    rchk("clamp_lo", ADDR_FILTER, 32'h1);
    $display("test registers done");
    settle();
    chkrun("blocked", 2'h0);
    sw[0] <= 1'b0;
    settle();
    sw[0] <= 1'b1;
    settle();
    chkrun("fwd", 2'h2);
    wr(ADDR_FUNC_BASE + 8'h04, 32'(FN_REV));
    wr(ADDR_FUNC_BASE + 8'h08, 32'(FN_STOP_EN));
    sw <= 7'h02;
    settle();
    chkrun("rev", 2'h3);
    wr(ADDR_RUNMODE, 32'h1);
    settle();
    chkrun("dir_only", 2'h0);
    sw <= 7'h03;
    settle();
    chkrun("run_rev", 2'h3);
    sw <= 7'h01;
    settle();
    chkrun("run_fwd", 2'h2);
    sw <= 7'h00;
    wr(ADDR_RUNMODE, 32'h2);
    settle();
    trig(0, "no_enable", 2'h0);
    sw[2] <= 1'b1;
    settle();
    trig(0, "trig_fwd", 2'h2);
    trig(1, "trig_rev", 2'h3);
    sw[2] <= 1'b0;
    settle();
    chkrun("stop2", 2'h0);
    wr(ADDR_RUNMODE, 32'h3);
    sw[2] <= 1'b1;
    settle();
    trig(1, "dir_alone", 2'h0);
    trig(0, "run_start", 2'h2);
    trig(1, "dir_flip", 2'h3);
    sw[2] <= 1'b0;
    settle();
    chkrun("stop3", 2'h0);
    wr(ADDR_RUNMODE, 32'h0);
    $display("test run modes done");
    foreach (rows[i]) begin
      wr(ADDR_CONFIG, 32'(rows[i].cfg));
      wr(ADDR_FUNC_BASE, 32'(rows[i].fn));
      sw[0] <= 1'b1;
      settle();
      chk("levels", 32'(rows[i].exp), 32'(lv));
      sw[0] <= 1'b0;
      settle();
    end
    $display("test function table done");
    wr(ADDR_CONFIG, 32'h0);
    wr(ADDR_FUNC_BASE + 8'h0C, 32'(FN_LOCK_ONE));
    wr(ADDR_POLARITY, 32'h08);
    settle();
    chk("inverted", 32'h1, 32'(open_collector_out_one));
    wr(ADDR_POLARITY, 32'h00);
    settle();
    chk("normal", 32'h0, 32'(open_collector_out_one));
    wr(ADDR_FUNC_BASE + 8'h14, 32'(FN_PULSE_REF));
    sw[5] <= 1'b1;
    settle();
    chk("fast_ref", 32'h1, 32'(pulse_ref_level));
    sw[5] <= 1'b0;
    wr(ADDR_FUNC_BASE + 8'h0C, 32'(FN_CNT_TRIG));
    wr(ADDR_FUNC_BASE + 8'h10, 32'(FN_CNT_CLR));
    pulse(3);
    pulse(3);
    rchk("count_up", ADDR_COUNT, 32'h2);
    wr(ADDR_CONFIG, 32'h20);
    pulse(3);
    rchk("count_down", ADDR_COUNT, 32'h1);
    pulse(4);
    rchk("count_clr", ADDR_COUNT, 32'h0);
    wr(ADDR_CONFIG, 32'h08);
    wr(ADDR_FUNC_BASE, 32'(FN_SEQ_EN));
    sw[1] <= 1'b1;
    settle();
    chk("seq_zero", 32'h1, 32'({seq_enable, seq_zero_freq}));
    sw[0] <= 1'b1;
    settle();
    chk("seq_run", 32'h2, 32'({seq_enable, seq_zero_freq}));
    sw[1:0] <= 2'b00;
    wr(ADDR_FUNC_BASE + 8'h10, 32'(FN_SEQ_RST));
    settle();
    sw[4] <= 1'b1;
    settle();
    chk("seq_reset", 32'h1, 32'(seq_reset));
    sw[4] <= 1'b0;
    wr(ADDR_FUNC_BASE + 8'h0C, 32'(FN_TMR_TRIG));
    wr(ADDR_FUNC_BASE + 8'h10, 32'(FN_TMR_CLR));
    pulse(3);
    apb(1'b0, ADDR_TIMER, 32'h0);
    chk("timer_run", 32'h1, 32'(q != 32'h0));
    pulse(4);
    rchk("timer_clr", ADDR_TIMER, 32'h0);
    wr(ADDR_FUNC_BASE + 8'h14, 32'(FN_LEN_PULSE));
    pulse(5);
    chk("len_pulse", 32'h1, 32'(n_len));
    $display("test polarity and counter done");
    give_verdict();
  end
endmodule
